// >>> hdl/nv_cfg_consts.svh
// constants for the nonvolatile configuration word writer
`ifndef NV_CFG_CONSTS_SVH
`define NV_CFG_CONSTS_SVH

// ----------------------------------------
// bus addressing
// ----------------------------------------
`define DEV_ADDR_FIXED 4'h9
`define NVCFG_POINTER 8'h11

// ----------------------------------------
// word layout and reset values
// ----------------------------------------
`define NVCFG_FACTORY 16'h0000
`define NVCFG_WRITE_MASK 16'h7f06
`define NV_RES_HI 14
`define NV_RES_LO 13
`define NV_FQ_HI 12
`define NV_FQ_LO 11
`define NV_POL 10
`define NV_MODE 9
`define NV_SD 8
`define NV_LOCKDOWN 2
`define NV_LOCK 1
`define VOL_BASE 8

// ----------------------------------------
// timing
// ----------------------------------------
`define SYS_PERIOD_NS 20
`define PROGRAM_CYCLE_TIME_NS 80000
// longest time, so integer division rounds down
`define PROG_CYCLES ((`PROGRAM_CYCLE_TIME_NS) / (`SYS_PERIOD_NS))
`define PROG_CNT_W 12

`endif

// >>> hdl/nv_cfg_pkg.sv
// types shared by the configuration word writer
`include "nv_cfg_consts.svh"

package nv_cfg_pkg;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_ADDR = 4'h1,
      S_AACK = 4'h2,
      S_PTR = 4'h3,
      S_PACK = 4'h4,
      S_WDATA = 4'h5,
      S_WACK = 4'h6,
      S_RDATA = 4'h7,
      S_RACK = 4'h8,
      S_RLOAD = 4'h9
   } i2c_state_t;

   typedef struct packed {
      i2c_state_t state;
      logic scl_q;
      logic sda_q;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [7:0] tx;
      logic [7:0] pointer;
      logic rw;
      logic oe;
      logic [1:0] dcnt;
      logic [15:0] wword;
      logic busy_hit;
      logic rd_lo;
      logic [15:0] stored;
      logic [15:0] pend;
      logic busy;
      logic req_tog;
      logic done_s1;
      logic done_s2;
      logic done_seen;
      logic loaded;
      logic [7:0] vol;
   } link_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic seen;
      logic running;
      logic [`PROG_CNT_W-1:0] cnt;
      logic done_tog;
   } timer_state_t;

   typedef struct packed {
      logic [4:0] ff1;
      logic [4:0] ff2;
      logic [4:0] ff3;
      logic [4:0] filt;
   } filter_state_t;

endpackage : nv_cfg_pkg

// >>> hdl/pin_filter.sv
// three-stage synchroniser and agreement filter for the bus and strap pins
`timescale 1ns/10ps
`include "nv_cfg_consts.svh"

module pin_filter (
   input wire logic link_clk,
   input wire logic resetn,
   input wire logic [4:0] pins,
   output logic [4:0] filt
);

   nv_cfg_pkg::filter_state_t r;
   nv_cfg_pkg::filter_state_t next_r;

   // a bit moves only once stages two and three agree
   always_comb begin
      next_r = r;
      next_r.ff1 = pins;
      next_r.ff2 = r.ff1;
      next_r.ff3 = r.ff2;
      for (int i = 0; i < 5; i++) begin
         if (r.ff2[i] == r.ff3[i]) begin
            next_r.filt[i] = r.ff3[i];
         end
      end
   end

   // idle bus lines rest high
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.ff1 <= 5'h03;
         r.ff2 <= 5'h03;
         r.ff3 <= 5'h03;
         r.filt <= 5'h03;
      end else begin
         r <= next_r;
      end
   end

   assign filt = r.filt;

endmodule : pin_filter

// >>> hdl/program_timer.sv
// self-timed program cycle on the system clock
`timescale 1ns/10ps
`include "nv_cfg_consts.svh"

module program_timer (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic req_toggle,
   output logic done_toggle
);

   localparam logic [`PROG_CNT_W-1:0] LAST = `PROG_CNT_W'(`PROG_CYCLES - 1);

   nv_cfg_pkg::timer_state_t r;
   nv_cfg_pkg::timer_state_t next_r;

   always_comb begin
      next_r = r;
      next_r.s1 = req_toggle;
      next_r.s2 = r.s1;
      if (r.s2 != r.seen) begin
         next_r.seen = r.s2;
         next_r.running = 1'b1;
         next_r.cnt = '0;
      end else if (r.running) begin
         if (r.cnt == LAST) begin
            next_r.running = 1'b0;
            next_r.done_tog = !r.done_tog;
         end else begin
            next_r.cnt = r.cnt + `PROG_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign done_toggle = r.done_tog;

   AST_PROG_LENGTH: assert property (@(posedge sys_clk) disable iff (!resetn)
      $fell(r.running) |-> ($past(r.cnt) == LAST && r.done_tog != $past(r.done_tog)))
      else $error("program cycle ended at the wrong count");

endmodule : program_timer

// >>> hdl/nv_config_register_writer.sv
// two-wire slave holding the nonvolatile power-up configuration word
`timescale 1ns/10ps
`include "nv_cfg_consts.svh"

module nv_config_register_writer (
   input wire logic link_clk,
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [2:0] address_strap_pins,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic [1:0] conv_resolution_sel,
   output logic [1:0] fault_queue_sel,
   output logic [2:0] fault_queue_count,
   output logic alarm_active_high,
   output logic alarm_interrupt_mode,
   output logic shutdown_mode,
   output logic config_write_protect,
   output logic nonvolatile_busy,
   output logic [15:0] nonvolatile_power_up_config
);

   // ----------------------------------------
   // decoding helpers
   // ----------------------------------------
   function automatic logic [2:0] fq_count(input logic [1:0] sel);
      logic [2:0] c;
      c = 3'h1;
      unique case (sel)
         2'h0: c = 3'h1;
         2'h1: c = 3'h2;
         2'h2: c = 3'h4;
         2'h3: c = 3'h6;
      endcase
      return c;
   endfunction : fq_count

   // answer bytes; other pointers belong to registers outside this block
   function automatic logic [7:0] rd_byte(input logic [7:0] ptr,
                                           input logic [15:0] word,
                                           input logic lo);
      logic [7:0] b;
      b = 8'h00;
      if (ptr == `NVCFG_POINTER) begin
         b = lo ? word[7:0] : word[15:8];
      end
      return b;
   endfunction : rd_byte

   // returns {program, new word}
   function automatic logic [16:0] commit_word(input logic [15:0] s,
                                               input logic [15:0] w);
      logic [16:0] res;
      res = {1'b0, s};
      if (s[`NV_LOCKDOWN]) begin
         res = {1'b0, s};
      end else if (s[`NV_LOCK]) begin
         // only a clear of the lock bit goes through, everything else kept
         if (!w[`NV_LOCK]) begin
            res = {1'b1, s & ~(16'h0001 << `NV_LOCK)};
         end
      end else begin
         // lockdown can only be added, never removed
         res = {1'b1, (w & `NVCFG_WRITE_MASK) | (s & (16'h0001 << `NV_LOCKDOWN))};
      end
      return res;
   endfunction : commit_word

   // ----------------------------------------
   // pin synchronisers and program timer
   // ----------------------------------------
   logic [4:0] filt;
   logic done_toggle;

   pin_filter u_pin_filter (
      .link_clk(link_clk),
      .resetn(resetn),
      .pins({address_strap_pins, scl_in, sda_in}),
      .filt(filt)
   );

   nv_cfg_pkg::link_state_t r;
   nv_cfg_pkg::link_state_t next_r;

   program_timer u_program_timer (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .req_toggle(r.req_tog),
      .done_toggle(done_toggle)
   );

   // ----------------------------------------
   // bus events
   // ----------------------------------------
   logic scl;
   logic sda;
   logic [2:0] strap;
   logic rise;
   logic fall;
   logic start_ev;
   logic stop_ev;
   logic done_ev;
   logic valid_wr;
   logic [16:0] cw;

   assign sda = filt[0];
   assign scl = filt[1];
   assign strap = filt[4:2];
   assign rise = scl && !r.scl_q;
   assign fall = !scl && r.scl_q;
   assign start_ev = scl && r.scl_q && r.sda_q && !sda;
   assign stop_ev = scl && r.scl_q && !r.sda_q && sda;
   assign done_ev = r.done_s2 != r.done_seen;
   // at least two full bytes, right pointer, no busy seen on the way
   assign valid_wr = !r.rw && r.pointer == `NVCFG_POINTER && r.dcnt == 2'h2 &&
                     !r.busy_hit && !r.busy;
   assign cw = commit_word(r.stored, r.wword);

   // ----------------------------------------
   // protocol engine
   // ----------------------------------------
   always_comb begin
      next_r = r;
      next_r.scl_q = scl;
      next_r.sda_q = sda;
      next_r.done_s1 = done_toggle;
      next_r.done_s2 = r.done_s1;
      if (done_ev) begin
         next_r.done_seen = r.done_s2;
         next_r.stored = r.pend;
         next_r.busy = 1'b0;
      end
      // the volatile copy is taken once, right after reset lets go
      if (!r.loaded) begin
         next_r.loaded = 1'b1;
         next_r.vol = r.stored[15:8];
      end
      if (start_ev || stop_ev) begin
         // a repeated start simply drops the collected bytes
         if (stop_ev && valid_wr && cw[16]) begin
            next_r.pend = cw[15:0];
            next_r.busy = 1'b1;
            next_r.req_tog = !r.req_tog;
         end
         next_r.state = start_ev ? nv_cfg_pkg::S_ADDR : nv_cfg_pkg::S_IDLE;
         next_r.cnt = 4'h0;
         next_r.oe = 1'b0;
         next_r.dcnt = 2'h0;
         next_r.busy_hit = 1'b0;
      end else begin
         unique case (r.state)
            nv_cfg_pkg::S_IDLE: begin
               next_r.oe = 1'b0;
            end
            nv_cfg_pkg::S_ADDR, nv_cfg_pkg::S_PTR, nv_cfg_pkg::S_WDATA: begin
               if (rise) begin
                  next_r.shreg = {r.shreg[6:0], sda};
                  next_r.cnt = r.cnt + 4'h1;
               end else if (fall && r.cnt == 4'h8) begin
                  next_r.cnt = 4'h0;
                  if (r.state == nv_cfg_pkg::S_ADDR) begin
                     if (r.shreg[7:1] == {`DEV_ADDR_FIXED, strap}) begin
                        next_r.rw = r.shreg[0];
                        next_r.oe = 1'b1;
                        next_r.state = nv_cfg_pkg::S_AACK;
                     end else begin
                        next_r.state = nv_cfg_pkg::S_IDLE;
                     end
                  end else if (r.state == nv_cfg_pkg::S_PTR) begin
                     next_r.pointer = r.shreg;
                     next_r.oe = 1'b1;
                     next_r.state = nv_cfg_pkg::S_PACK;
                  end else begin
                     next_r.oe = 1'b1;
                     if (r.pointer == `NVCFG_POINTER) begin
                        if (r.dcnt == 2'h0) begin
                           next_r.wword[15:8] = r.shreg;
                        end
                        if (r.dcnt == 2'h1) begin
                           next_r.wword[7:0] = r.shreg;
                        end
                        if (r.dcnt != 2'h2) begin
                           next_r.dcnt = r.dcnt + 2'h1;
                        end
                        if (r.busy) begin
                           next_r.busy_hit = 1'b1;
                           next_r.oe = 1'b0;
                        end
                     end
                     next_r.state = nv_cfg_pkg::S_WACK;
                  end
               end
            end
            nv_cfg_pkg::S_AACK: begin
               if (fall) begin
                  if (r.rw) begin
                     next_r.rd_lo = 1'b0;
                     next_r.tx = rd_byte(r.pointer, r.stored, 1'b0);
                     next_r.oe = !next_r.tx[7];
                     next_r.state = nv_cfg_pkg::S_RDATA;
                  end else begin
                     next_r.oe = 1'b0;
                     next_r.state = nv_cfg_pkg::S_PTR;
                  end
               end
            end
            nv_cfg_pkg::S_PACK: begin
               if (fall) begin
                  next_r.oe = 1'b0;
                  next_r.dcnt = 2'h0;
                  next_r.state = nv_cfg_pkg::S_WDATA;
               end
            end
            nv_cfg_pkg::S_WACK: begin
               if (fall) begin
                  next_r.oe = 1'b0;
                  next_r.state = nv_cfg_pkg::S_WDATA;
               end
            end
            nv_cfg_pkg::S_RDATA: begin
               if (fall) begin
                  if (r.cnt == 4'h7) begin
                     next_r.oe = 1'b0;
                     next_r.cnt = 4'h0;
                     next_r.state = nv_cfg_pkg::S_RACK;
                  end else begin
                     next_r.tx = {r.tx[6:0], 1'b0};
                     next_r.oe = !r.tx[6];
                     next_r.cnt = r.cnt + 4'h1;
                  end
               end
            end
            nv_cfg_pkg::S_RACK: begin
               // a nack ends the answer; an ack after the low byte wraps to the high
               if (rise) begin
                  if (sda) begin
                     next_r.state = nv_cfg_pkg::S_IDLE;
                  end else begin
                     next_r.rd_lo = !r.rd_lo;
                     next_r.state = nv_cfg_pkg::S_RLOAD;
                  end
               end
            end
            nv_cfg_pkg::S_RLOAD: begin
               if (fall) begin
                  next_r.tx = rd_byte(r.pointer, r.stored, r.rd_lo);
                  next_r.oe = !next_r.tx[7];
                  next_r.cnt = 4'h0;
                  next_r.state = nv_cfg_pkg::S_RDATA;
               end
            end
            default: begin
               next_r.oe = 1'b0;
               next_r.state = nv_cfg_pkg::S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
         r.stored <= `NVCFG_FACTORY;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign sda_out = 1'b0;
   assign sda_oe = r.oe;
   assign conv_resolution_sel = r.vol[`NV_RES_HI-`VOL_BASE:`NV_RES_LO-`VOL_BASE];
   assign fault_queue_sel = r.vol[`NV_FQ_HI-`VOL_BASE:`NV_FQ_LO-`VOL_BASE];
   assign fault_queue_count = fq_count(fault_queue_sel);
   assign alarm_active_high = r.vol[`NV_POL-`VOL_BASE];
   assign alarm_interrupt_mode = r.vol[`NV_MODE-`VOL_BASE];
   assign shutdown_mode = r.vol[`NV_SD-`VOL_BASE];
   // protection seen by the volatile and limit registers elsewhere
   assign config_write_protect = r.stored[`NV_LOCK] || r.stored[`NV_LOCKDOWN];
   assign nonvolatile_busy = r.busy;
   assign nonvolatile_power_up_config = r.stored;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (!resetn);

   AST_LOCKDOWN_STICKY: assert property (
      $past(r.stored[`NV_LOCKDOWN]) |-> r.stored[`NV_LOCKDOWN])
      else $error("lockdown bit returned to zero");

   AST_LOCKDOWN_FROZEN: assert property (
      r.stored[`NV_LOCKDOWN] && $past(r.stored[`NV_LOCKDOWN]) |-> $stable(r.stored))
      else $error("word changed under lockdown");

   AST_LOCK_ONLY_CLEAR: assert property (
      $past(r.stored[`NV_LOCK]) && !$changed(r.stored) == 1'b0 |->
      r.stored == ($past(r.stored) & ~(16'h0001 << `NV_LOCK)))
      else $error("locked word changed beyond lock clear");

   AST_RESERVED_ZERO: assert property (
      (r.stored & ~`NVCFG_WRITE_MASK) == 16'h0000)
      else $error("reserved bit set in stored word");

   AST_STORE_ON_DONE: assert property (
      $changed(r.stored) |-> $past(done_ev) && $fell(r.busy))
      else $error("stored word changed outside program completion");

   AST_BUSY_FROM_STOP: assert property (
      $rose(r.busy) |-> $past(stop_ev) && $past(valid_wr))
      else $error("program started without a valid stop");

   AST_NO_PROG_WHILE_BUSY: assert property (
      $changed(r.req_tog) |-> !$past(r.busy))
      else $error("program requested while busy");

   AST_RSTART_ABORT: assert property (
      start_ev |=> !$rose(r.busy))
      else $error("repeated start launched a program");

   AST_BUSY_NACK: assert property (
      r.state == nv_cfg_pkg::S_WDATA && fall && r.cnt == 4'h8 &&
      r.pointer == `NVCFG_POINTER && r.busy |=> !r.oe && r.state == nv_cfg_pkg::S_WACK)
      else $error("data byte acknowledged while busy");

   AST_LOCK_ACK: assert property (
      r.state == nv_cfg_pkg::S_WDATA && fall && r.cnt == 4'h8 && !r.busy |=>
      r.oe && r.state == nv_cfg_pkg::S_WACK)
      else $error("data byte not acknowledged");

   AST_VOL_COPY: assert property (
      !r.loaded |=> r.vol == $past(r.stored[15:8]))
      else $error("volatile copy missed after reset");

endmodule : nv_config_register_writer

// >>> tb/i2c_master_model.sv
// two-wire bus controller model that drives the configuration writer
`timescale 1ns/10ps

module i2c_master_model (
   input wire logic link_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // ------------------------------------------------------------
   // bus phases
   // ------------------------------------------------------------
   // 12 link clocks a phase leaves margin over the device pin filter
   localparam int PHASE = 12;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic phase();
      repeat (PHASE) @(posedge link_clk);
      #1;
   endtask : phase

   // start or repeated start: data falls while the clock is high
   task automatic start();
      sda_low = 1'b0;
      phase();
      scl = 1'b1;
      phase();
      sda_low = 1'b1;
      phase();
      scl = 1'b0;
      phase();
   endtask : start

   task automatic stop();
      sda_low = 1'b1;
      phase();
      scl = 1'b1;
      phase();
      sda_low = 1'b0;
      phase();
   endtask : stop

   // one clock pulse; the wire is sampled in the middle of the high phase
   task automatic bit_xfer(input logic b, output logic r);
      sda_low = ~b;
      phase();
      scl = 1'b1;
      phase();
      r = sda;
      phase();
      scl = 1'b0;
      phase();
   endtask : bit_xfer

   // send a byte msb first and report whether the device acknowledged
   task automatic send_byte(input logic [7:0] d, output logic acked);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], r);
      end
      bit_xfer(1'b1, r);
      acked = ~r;
   endtask : send_byte

   // take a byte; ack asks for more, nack ends the read
   task automatic recv_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, r);
         d[i] = r;
      end
      bit_xfer(~more, r);
   endtask : recv_byte
endmodule : i2c_master_model

// >>> tb/nv_config_register_writer_test.sv
// self-checking bench for the nonvolatile configuration word writer
`timescale 1ns/10ps
`include "nv_cfg_consts.svh"

module nv_config_register_writer_test;
   localparam logic [2:0] STRAP = 3'h5;
   logic sys_clk;
   logic link_clk;
   logic resetn;
   logic [2:0] address_strap_pins;
   logic scl;
   logic sda_low;
   logic sda;
   logic sda_out;
   logic sda_oe;
   logic [1:0] conv_resolution_sel;
   logic [1:0] fault_queue_sel;
   logic [2:0] fault_queue_count;
   logic alarm_active_high;
   logic alarm_interrupt_mode;
   logic shutdown_mode;
   logic config_write_protect;
   logic nonvolatile_busy;
   logic [15:0] nonvolatile_power_up_config;
   logic [15:0] v;
   int mismatches;
   int checked;

   // open-drain data wire with a pull-up
   assign sda = !(sda_low || (sda_oe && !sda_out));

   nv_config_register_writer DUT (
      .link_clk(link_clk),
      .sys_clk(sys_clk),
      .resetn(resetn),
      .address_strap_pins(address_strap_pins),
      .scl_in(scl),
      .sda_in(sda),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .conv_resolution_sel(conv_resolution_sel),
      .fault_queue_sel(fault_queue_sel),
      .fault_queue_count(fault_queue_count),
      .alarm_active_high(alarm_active_high),
      .alarm_interrupt_mode(alarm_interrupt_mode),
      .shutdown_mode(shutdown_mode),
      .config_write_protect(config_write_protect),
      .nonvolatile_busy(nonvolatile_busy),
      .nonvolatile_power_up_config(nonvolatile_power_up_config)
   );

   i2c_master_model m (
      .link_clk(link_clk),
      .sda(sda),
      .scl(scl),
      .sda_low(sda_low)
   );

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // link clock offset so the two domains never line up
   initial begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic do_reset();
      resetn = 1'b0;
      repeat (10) @(posedge sys_clk);
      #1 resetn = 1'b1;
      repeat (20) @(posedge link_clk);
   endtask : do_reset

   // write nb data bytes to the word; a third byte is filler
   task automatic wr(input logic [15:0] w, input int nb, input logic rs, input logic dack);
      logic a;
      m.start();
      m.send_byte({`DEV_ADDR_FIXED, STRAP, 1'b0}, a);
      check(16'(a), 16'h1);
      m.send_byte(`NVCFG_POINTER, a);
      check(16'(a), 16'h1);
      for (int i = 0; i < nb; i++) begin
         m.send_byte(i == 0 ? w[15:8] : (i == 1 ? w[7:0] : 8'hc3), a);
         check(16'(a), 16'(dack));
      end
      if (rs) begin
         m.start();
      end else begin
         m.stop();
      end
   endtask : wr

   // the pointer still selects the word from the last write
   task automatic rd(input logic started, output logic [15:0] r);
      logic a;
      if (!started) begin
         m.start();
      end
      m.send_byte({`DEV_ADDR_FIXED, STRAP, 1'b1}, a);
      check(16'(a), 16'h1);
      m.recv_byte(1'b1, r[15:8]);
      m.recv_byte(1'b0, r[7:0]);
      m.stop();
   endtask : rd

   // busy must show as expected, then clear in bounded time before reads
   task automatic prog(input logic go);
      int n;
      repeat (20) @(posedge sys_clk);
      check(16'(nonvolatile_busy), 16'(go));
      n = 0;
      while (nonvolatile_busy !== 1'b0 && n < `PROG_CYCLES) begin
         @(posedge sys_clk);
         n++;
      end
      check(16'(n < `PROG_CYCLES), 16'h1);
   endtask : prog

   task automatic wr_chk(input logic [15:0] w, input logic go, input logic [15:0] exp);
      wr(w, 2, 1'b0, 1'b1);
      prog(go);
      check(nonvolatile_power_up_config, exp);
   endtask : wr_chk

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      logic a;
      mismatches = 0;
      checked = 0;
      resetn = 1'b0;
      address_strap_pins = STRAP;
      do_reset();
      check(nonvolatile_power_up_config, 16'h0000);
      check(16'({conv_resolution_sel, fault_queue_sel}), 16'h0);
      check(16'({alarm_active_high, alarm_interrupt_mode, shutdown_mode}), 16'h0);
      check(16'(fault_queue_count), 16'h1);
      check(16'({config_write_protect, nonvolatile_busy}), 16'h0);
      $display("test factory state done");
      wr(16'hbff9, 3, 1'b0, 1'b1);
      prog(1'b1);
      check(nonvolatile_power_up_config, 16'h3f00);
      // the volatile copy is only refreshed by a reset
      check(16'({conv_resolution_sel, fault_queue_sel}), 16'h0);
      rd(1'b0, v);
      check(v, 16'h3f00);
      $display("test write and read back done");
      wr(16'h1200, 1, 1'b0, 1'b1);
      prog(1'b0);
      check(nonvolatile_power_up_config, 16'h3f00);
      $display("test short write done");
      wr(16'h1200, 2, 1'b1, 1'b1);
      prog(1'b0);
      rd(1'b1, v);
      check(v, 16'h3f00);
      $display("test repeated start abort done");
      m.start();
      m.send_byte({`DEV_ADDR_FIXED, 3'h2, 1'b0}, a);
      check(16'(a), 16'h0);
      m.stop();
      $display("test foreign address done");
      // second write lands while the first is still programming
      wr(16'h1200, 2, 1'b0, 1'b1);
      wr(16'h7f00, 2, 1'b0, 1'b0);
      prog(1'b1);
      check(nonvolatile_power_up_config, 16'h1200);
      $display("test write while busy done");
      wr_chk(16'h0002, 1'b1, 16'h0002);
      check(16'(config_write_protect), 16'h1);
      wr_chk(16'h7f02, 1'b0, 16'h0002);
      wr_chk(16'h7f00, 1'b1, 16'h0000);
      $display("test reversible lock done");
      wr_chk(16'h0006, 1'b1, 16'h0006);
      wr_chk(16'h0000, 1'b0, 16'h0006);
      wr_chk(16'h7f02, 1'b0, 16'h0006);
      check(16'(config_write_protect), 16'h1);
      $display("test lockdown done");
      tally_and_finish();
   end

   // the tests need about a millisecond of bus traffic and program cycles
   initial begin
      #1800000;
      mismatches++;
      tally_and_finish();
   end
endmodule : nv_config_register_writer_test
